// ---- design/sep_pkg.sv ----
// Package for the serial programming-port controller (programmer side).
// Assumes one clock domain (pclk) and an APB slave for software access.
package sep_pkg;
    // ********************************************************************
    // Register map of the controller's own APB registers
    // ********************************************************************
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CMD = 12'h004;
    localparam logic [11:0] ADDR_RESP = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [11:0] ADDR_DIV = 12'h010;
    // CTRL bit positions.
    localparam int CTRL_ENTRY = 0;
    localparam int CTRL_GO = 1;
    // STAT bit positions.
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_FIRST = 3;
    // ********************************************************************
    // Link protocol figures
    // ********************************************************************
    localparam logic [9:0] ENTRY_OPCODE = 10'h34b;
    localparam int ENTRY_BITS = 10;
    localparam int WORD_BITS = 32;
    localparam int CMD_DATA_SEL = 29;
    localparam int CMD_CODE_SEL = 28;
    localparam int CMD_READ = 24;
    localparam logic [31:0] CMD_RSVD_MASK = 32'hcef80000;
    // Sample delay after rising serial clock, in ns, and in pclk cycles.
    localparam int ACCESS_NS = 500;
    localparam int CLK_NS = 4;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] DIV_RESET = 16'h0100;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ENTRY = 6'b000010,
        ST_SHIFT = 6'b000100,
        ST_LAUNCH = 6'b001000,
        ST_WAIT = 6'b010000,
        ST_SETTLE = 6'b100000
    } sep_state_type;
endpackage

// ---- design/sep_sync.sv ----
// Two flip-flop synchroniser for one level from outside the pclk domain.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/1ps
module sep_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    // Only the second stage is read by anyone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule

// ---- design/sep_clkgen.sv ----
// Serial clock divider: produces one rising and one falling link edge.
// Assumes half_period is at least one; runs only while enable is high.
`timescale 1ns/1ps
module sep_clkgen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    input wire logic [15:0] half_period,
    output logic sclk,
    output logic rise,
    output logic fall
);
    logic [15:0] cnt_ff;
    // Each half period flips the clock; edges are one-cycle strobes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0000;
            sclk <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else if (ce) begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (!run) begin
                cnt_ff <= 16'h0000;
                sclk <= 1'b0;
            end else if (cnt_ff + 16'h0001 >= half_period) begin
                cnt_ff <= 16'h0000;
                sclk <= ~sclk;
                rise <= ~sclk;
                fall <= sclk;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
endmodule

// ---- design/sep_host.sv ----
// Programmer-side controller for the serial programming port.
// Assumes APB from software on pclk and a device pin sout asynchronous to pclk.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
module sep_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic load_ff,
    output logic sin_ff,
    output logic sclk_ff,
    input wire logic sout
);
    // ********************************************************************
    // Registers and state
    // ********************************************************************
    sep_pkg::sep_state_type state_ff;
    logic [31:0] cmd_ff;
    logic [31:0] resp_ff;
    logic [31:0] shreg_ff;
    logic [5:0] bits_ff;
    logic [1:0] pulses_ff;
    logic [15:0] div_ff;
    logic done_ff;
    logic refused_ff;
    logic first_ff;
    logic entry_pend_ff;
    logic [7:0] acc_ff;
    logic acc_run_ff;
    logic sout_s;
    logic sclk_w;
    logic rise_w;
    logic fall_w;
    logic run_w;
    logic wr_go;
    logic wr_entry;
    logic bad_cmd;
    logic sample_now;

    // Device serial output crosses into pclk first.
    sep_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(sout),
        .dout(sout_s)
    );

    assign run_w = (state_ff == sep_pkg::ST_ENTRY) || (state_ff == sep_pkg::ST_SHIFT)
        || (state_ff == sep_pkg::ST_LAUNCH);

    sep_clkgen u_clk (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(run_w),
        .half_period(div_ff),
        .sclk(sclk_w),
        .rise(rise_w),
        .fall(fall_w)
    );

    // ********************************************************************
    // APB slave
    // ********************************************************************
    // Answers in the access cycle itself; pready is a flip-flop held high.
    assign wr_go = ce && psel && penable && pwrite && (paddr == sep_pkg::ADDR_CTRL)
        && pwdata[sep_pkg::CTRL_GO];
    assign wr_entry = ce && psel && penable && pwrite && (paddr == sep_pkg::ADDR_CTRL)
        && pwdata[sep_pkg::CTRL_ENTRY];
    assign bad_cmd = |(cmd_ff & sep_pkg::CMD_RSVD_MASK)
        || (cmd_ff[sep_pkg::CMD_DATA_SEL] && cmd_ff[sep_pkg::CMD_CODE_SEL]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                if (paddr == sep_pkg::ADDR_CMD) begin
                    prdata <= cmd_ff;
                end else if (paddr == sep_pkg::ADDR_RESP) begin
                    prdata <= resp_ff;
                end else if (paddr == sep_pkg::ADDR_STAT) begin
                    prdata <= {28'h0000000, first_ff, refused_ff, done_ff,
                        state_ff != sep_pkg::ST_IDLE};
                end else if (paddr == sep_pkg::ADDR_DIV) begin
                    prdata <= {16'h0000, div_ff};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end

    // Command word and clock divider are software-written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= 32'h00000000;
            div_ff <= sep_pkg::DIV_RESET;
        end else if (ce && psel && penable && pwrite) begin
            if (paddr == sep_pkg::ADDR_CMD) begin
                cmd_ff <= pwdata;
            end else if (paddr == sep_pkg::ADDR_DIV && pwdata[15:0] != 16'h0000) begin
                div_ff <= pwdata[15:0];
            end
        end
    end

    // ********************************************************************
    // Link sequencer
    // ********************************************************************
    // Access-delay counter: starts on each rising link edge in ST_SHIFT.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= 8'h00;
            acc_run_ff <= 1'b0;
        end else if (ce) begin
            if (rise_w && state_ff == sep_pkg::ST_SHIFT) begin
                acc_ff <= 8'h00;
                acc_run_ff <= 1'b1;
            end else if (acc_run_ff) begin
                acc_ff <= acc_ff + 8'h01;
                if (acc_ff == 8'(sep_pkg::ACCESS_CYC - 1)) begin
                    acc_run_ff <= 1'b0;
                end
            end
        end
    end
    assign sample_now = acc_run_ff && (acc_ff == 8'(sep_pkg::ACCESS_CYC - 1));

    // Main sequencer. Busy requests are ignored and never queued.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= sep_pkg::ST_IDLE;
            load_ff <= 1'b0;
            sin_ff <= 1'b0;
            sclk_ff <= 1'b0;
            shreg_ff <= 32'h00000000;
            resp_ff <= 32'h00000000;
            bits_ff <= 6'h00;
            pulses_ff <= 2'h0;
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
            first_ff <= 1'b0;
            entry_pend_ff <= 1'b0;
        end else if (ce) begin
            sclk_ff <= sclk_w;
            case (state_ff)
                sep_pkg::ST_IDLE: begin
                    load_ff <= 1'b0;
                    if (wr_entry) begin
                        // software issues this right after releasing device reset.
                        shreg_ff <= {sep_pkg::ENTRY_OPCODE, 22'h000000};
                        bits_ff <= 6'(sep_pkg::ENTRY_BITS);
                        first_ff <= 1'b1;
                        entry_pend_ff <= 1'b1;
                        done_ff <= 1'b0;
                        state_ff <= sep_pkg::ST_ENTRY;
                    end else if (wr_go) begin
                        done_ff <= 1'b0;
                        if (bad_cmd) begin
                            refused_ff <= 1'b1;
                        end else begin
                            refused_ff <= 1'b0;
                            shreg_ff <= cmd_ff;
                            bits_ff <= 6'(sep_pkg::WORD_BITS);
                            load_ff <= 1'b1;
                            state_ff <= sep_pkg::ST_SHIFT;
                        end
                    end
                end
                sep_pkg::ST_ENTRY: begin
                    // Data changes on falling edge, valid at next rising edge.
                    if (fall_w || bits_ff == 6'(sep_pkg::ENTRY_BITS)) begin
                        if (bits_ff == 6'h00) begin
                            state_ff <= sep_pkg::ST_SETTLE;
                        end else begin
                            sin_ff <= shreg_ff[31];
                            shreg_ff <= {shreg_ff[30:0], 1'b0};
                            bits_ff <= bits_ff - 6'h01;
                        end
                    end
                end
                sep_pkg::ST_SHIFT: begin
                    if (sample_now) begin
                        resp_ff <= {resp_ff[30:0], sout_s};
                    end
                    if (fall_w || bits_ff == 6'(sep_pkg::WORD_BITS)) begin
                        if (bits_ff == 6'h00) begin
                            load_ff <= 1'b0;
                            pulses_ff <= 2'h2;
                            state_ff <= sep_pkg::ST_LAUNCH;
                        end else begin
                            sin_ff <= shreg_ff[31];
                            shreg_ff <= {shreg_ff[30:0], 1'b0};
                            bits_ff <= bits_ff - 6'h01;
                        end
                    end
                end
                sep_pkg::ST_LAUNCH: begin
                    sin_ff <= 1'b0;
                    if (fall_w) begin
                        pulses_ff <= pulses_ff - 2'h1;
                        if (pulses_ff == 2'h1) begin
                            state_ff <= sep_pkg::ST_WAIT;
                        end
                    end
                end
                sep_pkg::ST_WAIT: begin
                    if (sout_s) begin
                        done_ff <= 1'b1;
                        // The first command after entry captured the undefined word.
                        if (entry_pend_ff) begin
                            entry_pend_ff <= 1'b0;
                        end else begin
                            first_ff <= 1'b0;
                        end
                        state_ff <= sep_pkg::ST_IDLE;
                    end
                end
                sep_pkg::ST_SETTLE: begin
                    sin_ff <= 1'b0;
                    done_ff <= 1'b1;
                    state_ff <= sep_pkg::ST_IDLE;
                end
                default: begin
                    state_ff <= sep_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    property no_load_wait_p;
        @(posedge pclk) disable iff (!presetn)
        (state_ff == sep_pkg::ST_WAIT) |-> !load_ff;
    endproperty
    load_low_wait_a: assert property (no_load_wait_p)
        else $error("load high while waiting");
    raise_after_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(load_ff) |-> $past(state_ff) == sep_pkg::ST_IDLE)
        else $error("load rose outside idle");
    launch_load_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == sep_pkg::ST_LAUNCH) |-> !load_ff)
        else $error("load high during launch");
    shift_load_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == sep_pkg::ST_SHIFT) |-> load_ff)
        else $error("load low during shift");
    refuse_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && bad_cmd && state_ff == sep_pkg::ST_IDLE) |=> refused_ff && !load_ff)
        else $error("bad command not refused");
    done_on_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && state_ff == sep_pkg::ST_WAIT && sout_s) |=> done_ff)
        else $error("done not set on handshake");
    entry_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_entry && state_ff == sep_pkg::ST_IDLE) |=> state_ff == sep_pkg::ST_ENTRY
        && first_ff)
        else $error("entry not started");
    sample_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && rise_w && state_ff == sep_pkg::ST_SHIFT) |=> acc_run_ff && acc_ff == 8'h00)
        else $error("access delay not started");
    cover_entry_c: cover property (@(posedge pclk) state_ff == sep_pkg::ST_ENTRY);
    cover_launch_c: cover property (@(posedge pclk) state_ff == sep_pkg::ST_LAUNCH);
    cover_done_c: cover property (@(posedge pclk) $rose(done_ff));
    cover_refuse_c: cover property (@(posedge pclk) $rose(refused_ff));
endmodule

// ---- testbench/sep_device_model.sv ----
// Behavioural model of the device end of the serial programming link.
// Assumes the host drives load, serial in and the link clock; times are in ns.
`timescale 1ns/1ps
module sep_device_model #(
    parameter logic [10:0] INIT_ADDR = 11'h7f0,
    parameter logic [7:0] LOCK_MASK = 8'h03,
    parameter int WP_BIT = 7
) (
    input wire logic load_ff,
    input wire logic sin_ff,
    input wire logic sclk_ff,
    input wire logic slow,
    output logic sout,
    output logic prog_mode,
    output int n_cmds,
    output int n_bad
);
    logic [9:0] entry_sh = 10'h000;
    logic [31:0] cmd_sh = 32'h0;
    logic [31:0] resp_sh = 32'h0;
    logic [7:0] mem [logic [11:0]];
    logic [11:0] key;
    logic [7:0] rd;
    int nbits = 0;
    int nlaunch = 0;

    initial begin
        sout = 1'b1;
        prog_mode = 1'b0;
        n_cmds = 0;
        n_bad = 0;
    end

    // Runs one command; a malformed word is counted and writes nothing.
    task execute;
        key = {cmd_sh[28], cmd_sh[18:8]};
        rd = mem.exists(key) ? mem[key] : 8'hff;
        n_cmds++;
        if ((cmd_sh & 32'hcef80000) != 0 || cmd_sh[29] == cmd_sh[28]) begin
            n_bad++;
        end else if (!cmd_sh[24]) begin
            mem[key] = cmd_sh[7:0];
            if (key == {1'b0, INIT_ADDR} && rd[WP_BIT]) begin
                mem[key] = cmd_sh[7:0] | (rd & LOCK_MASK);
            end
            rd = cmd_sh[7:0];
        end
        // Don't-care bits carry a changing pattern so nobody relies on them.
        resp_sh = {~cmd_sh[31:19], cmd_sh[18:8], rd};
    endtask

    // ********************************************************************
    // Link clock edges
    // ********************************************************************
    // The output moves shortly after each rise, well inside the access delay.
    always @(posedge sclk_ff) begin
        if (!prog_mode) begin
            entry_sh = {entry_sh[8:0], sin_ff};
            if (entry_sh == 10'h34b) begin
                prog_mode = 1'b1;
                resp_sh = 32'ha5c33c5a;
            end
        end else if (load_ff) begin
            cmd_sh = {cmd_sh[30:0], sin_ff};
            nbits++;
            sout <= #50 resp_sh[31];
            resp_sh = {resp_sh[30:0], 1'b0};
        end else begin
            nlaunch++;
            sout <= #50 1'b0;
            if (nlaunch == 2) begin
                execute;
                #(slow ? 3000 : 200);
                sout = 1'b1;
            end
        end
    end

    // Framing checks on the host side of the link.
    always @(negedge load_ff) begin
        if (prog_mode && nbits != 32) n_bad++;
        nbits = 0;
        nlaunch = 0;
    end
    always @(posedge load_ff) begin
        if (n_cmds > 0 && (nlaunch != 2 || sout !== 1'b1)) n_bad++;
    end
endmodule

// ---- testbench/serial_eeprom_programming_port_test.sv ----
// Self-checking bench: APB tasks drive the controller, a device model answers.
// Assumes the design package, design modules and the device model are compiled first.
`timescale 1ns/1ps
module serial_eeprom_programming_port_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic slow = 1'b0;
    logic [31:0] prdata, q, cmd, r;
    logic pready, pslverr, load_ff, sin_ff, sclk_ff, sout, prog_mode;
    int n_cmds, n_bad, n;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 78;
    logic [7:0] mem [logic [11:0]];
    logic [31:0] exp_prev = 32'h0;
    logic first = 1'b1;
    logic [31:0] bad [2] = '{32'ha000_0000, 32'h3000_0000};

    always #2 pclk = ~pclk;

    sep_host u_sep_host (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_ff(load_ff),
        .sin_ff(sin_ff), .sclk_ff(sclk_ff), .sout(sout));
    sep_device_model u_sep_device_model (.load_ff(load_ff), .sin_ff(sin_ff),
        .sclk_ff(sclk_ff), .slow(slow), .sout(sout), .prog_mode(prog_mode),
        .n_cmds(n_cmds), .n_bad(n_bad));

    // ********************************************************************
    // Shared tasks
    // ********************************************************************
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; ends one edge after release so the next setup never collides.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rq);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100) begin
            k++;
            @(posedge pclk);
        end
        if (k >= 100) n_errors++;
        rq = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_idle(output logic [31:0] s);
        int k;
        k = 0;
        apb(1'b0, sep_pkg::ADDR_STAT, 32'h0, s);
        while (s[sep_pkg::STAT_BUSY] !== 1'b0 && k < 20000) begin
            k++;
            apb(1'b0, sep_pkg::ADDR_STAT, 32'h0, s);
        end
        if (k >= 20000) n_errors++;
    endtask

    // Sends one command; the reference memory predicts the response of the next one.
    task automatic run_cmd(input logic [31:0] c);
        logic [31:0] s;
        logic [11:0] key;
        logic [7:0] d;
        apb(1'b1, sep_pkg::ADDR_CMD, c, s);
        apb(1'b1, sep_pkg::ADDR_CTRL, 32'h2, s);
        wait_idle(s);
        check("status", {28'h0, first, 3'b010}, s & 32'hb);
        apb(1'b0, sep_pkg::ADDR_RESP, 32'h0, s);
        if (!first) check("response", exp_prev, s & 32'h7ffff);
        key = {c[28], c[18:8]};
        d = mem.exists(key) ? mem[key] : 8'hff;
        if (!c[24]) begin
            mem[key] = c[7:0];
            d = c[7:0];
        end
        exp_prev = {13'h0, c[18:8], d};
        first = 1'b0;
    endtask

    // Watchdog sized above the expected run of about 70k cycles.
    initial begin
        #380000;
        n_errors++;
        stop_test;
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, sep_pkg::ADDR_DIV, 32'h0, q);
        check("divider reset", {16'h0, sep_pkg::DIV_RESET}, q & 32'hffff);
        apb(1'b1, sep_pkg::ADDR_DIV, 32'h0, q);
        apb(1'b0, sep_pkg::ADDR_DIV, 32'h0, q);
        check("divider zero", {16'h0, sep_pkg::DIV_RESET}, q & 32'hffff);
        apb(1'b1, sep_pkg::ADDR_DIV, 32'h80, q);
        apb(1'b0, 12'h020, 32'h0, q);
        check("unmapped", 32'h0, q);
        apb(1'b1, sep_pkg::ADDR_CTRL, 32'h1, q);
        wait_idle(q);
        check("program mode", 32'h1, {31'h0, prog_mode});
        // Write then read back the same place, with random data, select and pace.
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            slow <= r[21];
            if (i % 2 == 0) begin
                cmd = (r[20] ? 32'h2000_0000 : 32'h1000_0000) | {14'h0, r[17:0]};
            end else begin
                cmd = (cmd & 32'hffff_ff00) | 32'h0100_0000;
            end
            run_cmd(cmd);
        end
        // Malformed words must stop in the controller without touching the link.
        for (int j = 0; j < 2; j++) begin
            n = n_cmds;
            apb(1'b1, sep_pkg::ADDR_CMD, bad[j], q);
            apb(1'b1, sep_pkg::ADDR_CTRL, 32'h2, q);
            wait_idle(q);
            check("refused", 32'h4, q & 32'h4);
            check("link quiet", n, n_cmds);
        end
        run_cmd(32'h1100_0000);
        check("device framing", 32'h0, n_bad);
        check("slave error", 32'h0, {31'h0, pslverr});
        stop_test;
    end
endmodule
